// *** cpt_defines.svh ***
// Purpose: Offsets, field positions, reset values and prescale counts
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, 16-bit registers
// Notes:   Operation list below is kept short on purpose
//
// Operation
// - Period match sets flag in timer/counter modes
// - Gated mode: gate falling edge sets flag
// - Flag stays set until software clears
// - Interrupt needs enable and non-zero priority
// - Zero period yields no interrupts
// - Join bit 3 forms 32-bit timer
// - Upper word is msw, lower word lsw
// - Only lower control used, except idle bit
// - Upper-word interrupt bits serve combined timer
// - Fixed pairs, lower-numbered timer is low word
// - Timer, gated, synchronous counter only
// - Internal clock or low-word external input
// - Clock source and gate bits select mode
// - Prescale bits 5:4 divide by 1/8/64/256
// - Prescaler cleared on low count or control writes, stop, reset
// - Enable bit 15 starts and stops timer
// - Low-word read copies upper count to holding
// - Low-word write loads upper count from holding
// - Holding transfers only in 32-bit operation
// - Modes behave as 16-bit, widened to 32
// - Match compares full 32-bit count and period
// - Gated count advances only while gate high
// - External input synchronised before counting
// - Runs in idle only if both idle bits clear
`ifndef CPT_DEFINES_SVH
`define CPT_DEFINES_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define CPT_OFF_LO_CTRL   8'h00
`define CPT_OFF_UP_CTRL   8'h04
`define CPT_OFF_CNT_LO    8'h08
`define CPT_OFF_CNT_HI    8'h0c
`define CPT_OFF_HOLD      8'h10
`define CPT_OFF_PER_LO    8'h14
`define CPT_OFF_PER_HI    8'h18
`define CPT_OFF_IRQ       8'h1c

// -----------------------------------------------------------------
// Control field positions
// -----------------------------------------------------------------
`define CPT_B_RUN         15
`define CPT_B_IDLE        13
`define CPT_B_GATE        6
`define CPT_B_PS_HI       5
`define CPT_B_PS_LO       4
`define CPT_B_JOIN        3
`define CPT_B_CS          1

// -----------------------------------------------------------------
// Interrupt register field positions
// -----------------------------------------------------------------
`define CPT_B_LO_FLAG     0
`define CPT_B_LO_EN       1
`define CPT_B_LO_PRIO_LO  4
`define CPT_B_LO_PRIO_HI  6
`define CPT_B_HI_FLAG     8
`define CPT_B_HI_EN       9
`define CPT_B_HI_PRIO_LO  12
`define CPT_B_HI_PRIO_HI  14

// -----------------------------------------------------------------
// Reset values and prescale terminal counts
// -----------------------------------------------------------------
`define CPT_RST_CTRL      16'h0000
`define CPT_RST_CNT       16'h0000
`define CPT_RST_PER       16'hffff
`define CPT_PS_TERM1      8'h00
`define CPT_PS_TERM8      8'h07
`define CPT_PS_TERM64     8'h3f
`define CPT_PS_TERM256    8'hff

`endif

// *** cpt_pkg.sv ***
// Purpose: Types shared by the timer pair modules
// Assumes: Nothing beyond the defines header
// Notes:   Asynchronous counting has no encoding here by design
package cpt_pkg;
	// Counting modes of the joined pair
	typedef enum logic [1:0] {
		CPT_MODE_TIMER,
		CPT_MODE_GATED,
		CPT_MODE_COUNTER
	} cpt_mode_t;
endpackage

// *** cpt_pre_if.sv ***
// Purpose: Carrier between the pair core and its prescaler
// Assumes: Same clock on both sides
// Notes:   tick_out is combinational in the prescaler
`timescale 1ns/1ps
interface cpt_pre_if;
	logic       tick_in;
	logic       clear;
	logic [1:0] sel;
	logic       tick_out;
	modport ctl (output tick_in, output clear, output sel, input tick_out);
	modport pre (input tick_in, input clear, input sel, output tick_out);
endinterface

// *** cpt_sync.sv ***
// Purpose: Two-flop synchroniser for a pin
// Assumes: Input is asynchronous to core_clk_i
// Notes:   Only the second flop is visible outside
`timescale 1ns/1ps
module cpt_sync (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// Pin and synchronised level
	input  wire logic pin_i,
	output logic      sync_o
);
	logic meta_r;

	// -----------------------------------------------------------------
	// Synchroniser chain
	// -----------------------------------------------------------------
	// First flop feeds only the second
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta_r <= pin_i;
			sync_o <= meta_r;
		end
	end
endmodule

// *** cpt_prescaler.sv ***
// Purpose: Input clock prescaler, 1/8/64/256
// Assumes: tick_in is a one-cycle enable pulse
// Notes:   clear wins over counting
`timescale 1ns/1ps
`include "cpt_defines.svh"
module cpt_prescaler (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// Control from the pair core
	cpt_pre_if.pre    pif
);
	logic [7:0] cnt_r;
	logic [7:0] term;

	// Terminal count for the selected ratio
	always_comb begin
		case (pif.sel)
			2'h0:    term = `CPT_PS_TERM1;
			2'h1:    term = `CPT_PS_TERM8;
			2'h2:    term = `CPT_PS_TERM64;
			default: term = `CPT_PS_TERM256;
		endcase
	end

	assign pif.tick_out = pif.tick_in & (cnt_r == term) & ~pif.clear;

	// Divider; clear drops any partial count
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 8'h00;
		end else if (pif.clear) begin
			cnt_r <= 8'h00;
		end else if (pif.tick_in) begin
			cnt_r <= (cnt_r == term) ? 8'h00 : cnt_r + 8'h01;
		end
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	property p_ps_clear;
		pif.clear |=> cnt_r == 8'h00;
	endproperty
	a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared");
endmodule

// *** cpt_timer32.sv ***
// Purpose: Joined 32-bit timer pair with Avalon-MM register access
// Assumes: idle_i comes from logic on core_clk_i, the count pin does not
// Notes:   16-bit-only modes are out of scope; the pair counts only when joined
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "cpt_defines.svh"
module cpt_timer32
	import cpt_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Device pins and power state
	input  wire logic        external_count_input_i,
	input  wire logic        idle_i,
	// Interrupt request towards the controller
	output logic             irq_o,
	output logic      [2:0]  irq_priority_level_o
);
	// This instance is one fixed pair: low word is the lower-numbered timer

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	logic [15:0] low_word_timer_control_r;
	logic [15:0] up_ctrl_r;
	logic [31:0] count_value_r;
	logic [15:0] upper_word_holding_r;
	logic [31:0] period_value_r;
	logic        period_irq_flag_r;
	logic        period_irq_enable_r;
	logic [2:0]  irq_priority_level_r;
	logic        lo_flag_r;
	logic        lo_en_r;
	logic [2:0]  lo_prio_r;
	logic        ext_prev_r;

	// -----------------------------------------------------------------
	// Decoded fields and events
	// -----------------------------------------------------------------
	logic        count_run_enable;
	logic        pair_join_mode;
	logic        gate_accumulate_enable;
	logic        clock_source_select;
	logic        idle_stop;
	logic        active;
	logic        ext_sync;
	logic        ext_rise;
	logic        gate_fall;
	logic        match;
	logic        period_zero;
	logic        set_ev;
	logic        clr_ev;
	cpt_mode_t   mode;

	// Bus access strobes
	logic        acc;
	logic        wr_acc;
	logic        rd_acc;
	logic        sel_lctl;
	logic        sel_uctl;
	logic        sel_clo;
	logic        sel_chi;
	logic        sel_hold;
	logic        sel_plo;
	logic        sel_phi;
	logic        sel_irq;
	logic [15:0] rdata_nxt;
	logic [15:0] irq_word;

	cpt_pre_if pif ();

	// Byte-lane merge for a 16-bit register in the low half-word
	function automatic logic [15:0] wmerge(input logic [15:0] old,
	                                       input logic [31:0] d,
	                                       input logic [3:0]  be);
		wmerge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	// -----------------------------------------------------------------
	// Control decode
	// -----------------------------------------------------------------
	// Apart from the idle bit, only the low-word control steers the pair
	assign count_run_enable       = low_word_timer_control_r[`CPT_B_RUN];
	assign pair_join_mode         = low_word_timer_control_r[`CPT_B_JOIN];
	assign gate_accumulate_enable = low_word_timer_control_r[`CPT_B_GATE];
	assign clock_source_select    = low_word_timer_control_r[`CPT_B_CS];

	// Either idle bit stops the pair while the core idles
	assign idle_stop = idle_i & (low_word_timer_control_r[`CPT_B_IDLE]
	                           | up_ctrl_r[`CPT_B_IDLE]);
	assign active    = count_run_enable & pair_join_mode & ~idle_stop;

	// Mode table; there is no asynchronous counter encoding
	always_comb begin
		if (clock_source_select) begin
			mode = CPT_MODE_COUNTER;
		end else if (gate_accumulate_enable) begin
			mode = CPT_MODE_GATED;
		end else begin
			mode = CPT_MODE_TIMER;
		end
	end

	// -----------------------------------------------------------------
	// External input
	// -----------------------------------------------------------------
	cpt_sync u_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.pin_i      (external_count_input_i),
		.sync_o     (ext_sync)
	);

	// Edge detect on the synchronised level only
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= ext_sync;
		end
	end

	assign ext_rise  = ext_sync & ~ext_prev_r;
	assign gate_fall = ~ext_sync & ext_prev_r;

	// -----------------------------------------------------------------
	// Prescaler
	// -----------------------------------------------------------------
	// Internal clock ticks every cycle; gated mode stalls while gate low
	always_comb begin
		case (mode)
			CPT_MODE_COUNTER: pif.tick_in = active & ext_rise;
			CPT_MODE_GATED:   pif.tick_in = active & ext_sync;
			default:          pif.tick_in = active;
		endcase
	end

	// Writes to low count or control, and a stopped timer, drop the partial count
	assign pif.clear = (wr_acc & (sel_clo | sel_lctl)) | ~count_run_enable;
	assign pif.sel   = low_word_timer_control_r[`CPT_B_PS_HI:`CPT_B_PS_LO];

	cpt_prescaler u_pre (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.pif        (pif)
	);

	// -----------------------------------------------------------------
	// Count, match and flag
	// -----------------------------------------------------------------
	assign match       = count_value_r == period_value_r;
	assign period_zero = period_value_r == 32'h0000_0000;
	assign set_ev      = ~period_zero & ((pif.tick_out & match & (mode != CPT_MODE_GATED))
	                   | (active & (mode == CPT_MODE_GATED) & gate_fall));
	assign clr_ev      = wr_acc & sel_irq & avs_byteenable_i[1]
	                   & avs_writedata_i[`CPT_B_HI_FLAG];

	// Count advances on the prescaled tick; software writes take the last word
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_value_r <= {`CPT_RST_CNT, `CPT_RST_CNT};
		end else begin
			if (pif.tick_out) begin
				if (match) begin
					count_value_r <= 32'h0000_0000;
				end else begin
					count_value_r <= count_value_r + 32'h0000_0001;
				end
			end
			if (wr_acc & sel_clo) begin
				count_value_r[15:0] <= wmerge(count_value_r[15:0], avs_writedata_i,
				                              avs_byteenable_i);
				if (pair_join_mode) begin
					count_value_r[31:16] <= upper_word_holding_r;
				end
			end
			if (wr_acc & sel_chi) begin
				count_value_r[31:16] <= wmerge(count_value_r[31:16], avs_writedata_i,
				                               avs_byteenable_i);
			end
		end
	end

	// Combined flag; a set in the clearing cycle wins
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			period_irq_flag_r <= 1'b0;
		end else if (set_ev) begin
			period_irq_flag_r <= 1'b1;
		end else if (clr_ev) begin
			period_irq_flag_r <= 1'b0;
		end
	end

	// Registered request; low-word interrupt bits never reach it
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o                <= 1'b0;
			irq_priority_level_o <= 3'h0;
		end else begin
			irq_o <= period_irq_flag_r & period_irq_enable_r
			       & (irq_priority_level_r != 3'h0);
			irq_priority_level_o <= irq_priority_level_r;
		end
	end

	// -----------------------------------------------------------------
	// Avalon-MM slave
	// -----------------------------------------------------------------
	// One wait cycle: the access acts at the first edge, data stand after it
	assign acc    = (avs_read_i | avs_write_i) & avs_waitrequest_o;
	assign wr_acc = acc & avs_write_i;
	assign rd_acc = acc & avs_read_i;

	assign irq_word = {1'b0, irq_priority_level_r, 2'h0, period_irq_enable_r, period_irq_flag_r,
	                   1'b0, lo_prio_r, 2'h0, lo_en_r, lo_flag_r};

	// Address decode and read mux; unmapped reads return zero
	always_comb begin
		sel_lctl  = 1'b0;
		sel_uctl  = 1'b0;
		sel_clo   = 1'b0;
		sel_chi   = 1'b0;
		sel_hold  = 1'b0;
		sel_plo   = 1'b0;
		sel_phi   = 1'b0;
		sel_irq   = 1'b0;
		rdata_nxt = 16'h0000;
		if (avs_address_i == `CPT_OFF_LO_CTRL) begin
			sel_lctl  = 1'b1;
			rdata_nxt = low_word_timer_control_r;
		end else if (avs_address_i == `CPT_OFF_UP_CTRL) begin
			sel_uctl  = 1'b1;
			rdata_nxt = up_ctrl_r;
		end else if (avs_address_i == `CPT_OFF_CNT_LO) begin
			sel_clo   = 1'b1;
			rdata_nxt = count_value_r[15:0];
		end else if (avs_address_i == `CPT_OFF_CNT_HI) begin
			sel_chi   = 1'b1;
			rdata_nxt = count_value_r[31:16];
		end else if (avs_address_i == `CPT_OFF_HOLD) begin
			sel_hold  = 1'b1;
			rdata_nxt = upper_word_holding_r;
		end else if (avs_address_i == `CPT_OFF_PER_LO) begin
			sel_plo   = 1'b1;
			rdata_nxt = period_value_r[15:0];
		end else if (avs_address_i == `CPT_OFF_PER_HI) begin
			sel_phi   = 1'b1;
			rdata_nxt = period_value_r[31:16];
		end else if (avs_address_i == `CPT_OFF_IRQ) begin
			sel_irq   = 1'b1;
			rdata_nxt = irq_word;
		end
	end

	// Wait-request and read data
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
		end else begin
			avs_waitrequest_o <= ~acc;
			if (rd_acc) begin
				avs_readdata_o <= {16'h0000, rdata_nxt};
			end
		end
	end

	// Control, period and interrupt-control registers
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_word_timer_control_r <= `CPT_RST_CTRL;
			up_ctrl_r                <= `CPT_RST_CTRL;
			period_value_r           <= {`CPT_RST_PER, `CPT_RST_PER};
			period_irq_enable_r      <= 1'b0;
			irq_priority_level_r     <= 3'h0;
			lo_flag_r                <= 1'b0;
			lo_en_r                  <= 1'b0;
			lo_prio_r                <= 3'h0;
		end else if (wr_acc) begin
			if (sel_lctl) begin
				low_word_timer_control_r <= wmerge(low_word_timer_control_r, avs_writedata_i,
				                                   avs_byteenable_i);
			end
			if (sel_uctl) begin
				up_ctrl_r <= wmerge(up_ctrl_r, avs_writedata_i, avs_byteenable_i);
			end
			if (sel_plo) begin
				period_value_r[15:0] <= wmerge(period_value_r[15:0], avs_writedata_i,
				                               avs_byteenable_i);
			end
			if (sel_phi) begin
				period_value_r[31:16] <= wmerge(period_value_r[31:16], avs_writedata_i,
				                                avs_byteenable_i);
			end
			if (sel_irq & avs_byteenable_i[1]) begin
				period_irq_enable_r  <= avs_writedata_i[`CPT_B_HI_EN];
				irq_priority_level_r <= avs_writedata_i[`CPT_B_HI_PRIO_HI:`CPT_B_HI_PRIO_LO];
			end
			// Low-word interrupt bits are stored only; the joined pair ignores them
			if (sel_irq & avs_byteenable_i[0]) begin
				lo_en_r   <= avs_writedata_i[`CPT_B_LO_EN];
				lo_prio_r <= avs_writedata_i[`CPT_B_LO_PRIO_HI:`CPT_B_LO_PRIO_LO];
				if (avs_writedata_i[`CPT_B_LO_FLAG]) begin
					lo_flag_r <= 1'b0;
				end
			end
		end
	end

	// Holding register: software write, or snapshot on a low-count read
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			upper_word_holding_r <= `CPT_RST_CNT;
		end else if (wr_acc & sel_hold) begin
			upper_word_holding_r <= wmerge(upper_word_holding_r, avs_writedata_i,
			                               avs_byteenable_i);
		end else if (rd_acc & sel_clo & pair_join_mode) begin
			upper_word_holding_r <= count_value_r[31:16];
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	property p_match_flag;
		pif.tick_out && match && !period_zero && mode != CPT_MODE_GATED |=> period_irq_flag_r;
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("match did not set flag");

	property p_gate_flag;
		active && mode == CPT_MODE_GATED && gate_fall && !period_zero |=> period_irq_flag_r;
	endproperty
	a_gate_flag: assert property (p_gate_flag) else $error("gate fall did not set flag");

	property p_flag_hold;
		period_irq_flag_r && !clr_ev |=> period_irq_flag_r;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped by hardware");

	property p_irq;
		period_irq_flag_r && period_irq_enable_r && irq_priority_level_r == 3'h0 |=> !irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("request with zero priority");

	property p_zero_period;
		period_zero && !period_irq_flag_r ##1 period_zero |-> !period_irq_flag_r;
	endproperty
	a_zero_period: assert property (p_zero_period) else $error("flag with zero period");

	property p_wrap;
		pif.tick_out && match && !(wr_acc && (sel_clo || sel_chi))
			|=> count_value_r == 32'h0000_0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("count did not restart");

	property p_hold_read;
		rd_acc && sel_clo && pair_join_mode |=> upper_word_holding_r == $past(count_value_r[31:16]);
	endproperty
	a_hold_read: assert property (p_hold_read) else $error("holding not captured");

	property p_hold_write;
		wr_acc && sel_clo && pair_join_mode |=> count_value_r[31:16] == $past(upper_word_holding_r);
	endproperty
	a_hold_write: assert property (p_hold_write) else $error("upper count not loaded");

	property p_stopped;
		!count_run_enable && !(wr_acc && (sel_clo || sel_chi)) |=> $stable(count_value_r);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped");

	property p_answer;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer late");
endmodule

// *** tb_cascaded_32bit_timer_pair.sv ***
// Purpose: Self-checking bench for the joined 32-bit timer pair
// Assumes: One-cycle Avalon-MM answer, 16-bit registers in the low half
// Notes:   Count windows allow a few cycles for bus and synchroniser delay
`timescale 1ns/1ps
module tb_cascaded_32bit_timer_pair;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        rd_s = 1'b0;
	logic        wr_s = 1'b0;
	logic        ext = 1'b0;
	logic        idle = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] v;
	logic        wreq;
	logic        irq;
	logic        seen;
	logic [2:0]  prio;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          k;

	// -----------------------------------------------------------------
	// Clock, device and bus tasks
	// -----------------------------------------------------------------
	// 40 MHz core clock
	always #12.5 clk = ~clk;

	cpt_timer32 uut (.core_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
		.avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'h3), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.external_count_input_i(ext), .idle_i(idle), .irq_o(irq),
		.irq_priority_level_o(prio));

	// Verdict and end of run
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Compare seen against expected
	task check(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask

	// Bounded wait for waitrequest low at a rising edge
	task ack;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (wreq === 1'b0)
				return;
		end
		n_mismatch++;
		wrap_up();
	endtask

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= {16'h0000, d};
		wr_s <= 1'b1;
		ack();
		wr_s <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		ack();
		v = rdata;
		rd_s <= 1'b0;
	endtask

	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		check(nm, v, e);
	endtask

	// Sample irq at each edge over a window; seen if any
	task watch(input int n);
		seen = 1'b0;
		repeat (n) begin
			@(posedge clk);
			if (irq === 1'b1)
				seen = 1'b1;
		end
	endtask

	// Stop and load a 32-bit count through the holding register
	task load(input logic [15:0] hi, input logic [15:0] lo);
		wr(8'h00, 16'h0008);
		wr(8'h10, hi);
		wr(8'h08, lo);
	endtask

	// -----------------------------------------------------------------
	// Test sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rchk("ctrl", 8'h00, 32'h0);
		rchk("per_hi", 8'h18, 32'hffff);
		rchk("unmapped", 8'h20, 32'h0);
		$display("test reset done");
		load(16'h1234, 16'h0005);
		rchk("cnt_hi", 8'h0c, 32'h1234);
		wr(8'h0c, 16'h00ab);
		wr(8'h10, 16'h0000);
		rchk("cnt_lo", 8'h08, 32'h0005);
		rchk("hold", 8'h10, 32'h00ab);
		wr(8'h00, 16'h0000);
		wr(8'h10, 16'h5555);
		wr(8'h08, 16'h0001);
		rchk("nojoin_hi", 8'h0c, 32'h00ab);
		rchk("nojoin_hold", 8'h10, 32'h5555);
		$display("test holding done");
		load(16'h0000, 16'hfff0);
		wr(8'h00, 16'h8008);
		repeat (100) @(posedge clk);
		wr(8'h00, 16'h0008);
		rchk("carry", 8'h0c, 32'h0001);
		$display("test carry done");
		load(16'h0000, 16'h0000);
		wr(8'h14, 16'h0003);
		wr(8'h18, 16'h0000);
		wr(8'h1c, 16'h0072);
		wr(8'h00, 16'h8008);
		watch(50);
		check("low_irq_bits", {31'h0, seen}, 32'h0);
		wr(8'h00, 16'h0008);
		repeat (20) @(posedge clk);
		rd(8'h1c);
		check("flag_kept", {31'h0, v[8]}, 32'h1);
		wr(8'h1c, 16'h0300);
		wr(8'h00, 16'h8008);
		watch(50);
		check("prio_zero", {31'h0, seen}, 32'h0);
		wr(8'h1c, 16'h1200);
		watch(4);
		check("irq", {31'h0, seen}, 32'h1);
		check("prio", {29'h0, prio}, 32'h1);
		wr(8'h00, 16'h0008);
		wr(8'h1c, 16'h1300);
		repeat (3) @(posedge clk);
		check("irq_clr", {31'h0, irq}, 32'h0);
		$display("test interrupt done");
		wr(8'h14, 16'h0000);
		load(16'h0000, 16'h0000);
		wr(8'h00, 16'h8008);
		watch(100);
		wr(8'h00, 16'h0008);
		rd(8'h1c);
		check("zero_period", {31'h0, seen | v[8]}, 32'h0);
		$display("test zero period done");
		wr(8'h14, 16'hffff);
		wr(8'h18, 16'hffff);
		for (k = 0; k < 4; k++) begin
			load(16'h0000, 16'h0000);
			wr(8'h00, 16'h8008 | 16'(k << 4));
			repeat (512) @(posedge clk);
			wr(8'h00, 16'h0008);
			rd(8'h08);
			check("prescale", {31'h0, v >= (512 >> (k * 3 - (k / 3))) &&
				v <= (512 >> (k * 3 - (k / 3))) + 4}, 32'h1);
		end
		$display("test prescale done");
		for (k = 0; k < 2; k++) begin
			load(16'h0000, 16'h0000);
			wr(8'h00, k ? 16'h804a : 16'h800a);
			repeat (6) begin
				repeat (4) @(posedge clk) ext <= 1'b1;
				repeat (4) @(posedge clk) ext <= 1'b0;
			end
			repeat (8) @(posedge clk);
			wr(8'h00, 16'h0008);
			rchk("edges", 8'h08, 32'h6);
		end
		$display("test counter done");
		load(16'h0000, 16'h0000);
		wr(8'h00, 16'h8048);
		repeat (40) @(posedge clk) ext <= 1'b1;
		@(posedge clk) ext <= 1'b0;
		repeat (10) @(posedge clk);
		wr(8'h00, 16'h0008);
		rd(8'h08);
		check("gated", {31'h0, v >= 38 && v <= 42}, 32'h1);
		rd(8'h1c);
		check("gate_flag", {31'h0, v[8]}, 32'h1);
		$display("test gated done");
		idle <= 1'b1;
		// Either halt bit stops the pair in idle; with both clear it keeps counting
		for (k = 0; k < 3; k++) begin
			load(16'h0000, 16'h0000);
			wr(8'h04, (k == 1) ? 16'h2000 : 16'h0000);
			wr(8'h00, (k == 0) ? 16'ha008 : 16'h8008);
			repeat (50) @(posedge clk);
			rd(8'h08);
			check("idle_halt", {31'h0, (k == 2) ? (v >= 50 && v <= 54) : (v == 0)}, 32'h1);
		end
		$display("test idle done");
		wrap_up();
	end
endmodule
